/* File: verilog/option_cfg_regs.vh */
`ifndef OPTION_CFG_REGS_VH
`define OPTION_CFG_REGS_VH
// ==========================================
// register byte offsets
`define REG_OPT0        12'h000
`define REG_OPT1        12'h004
`define REG_CTRL        12'h008
`define REG_STATUS      12'h00c
`define REG_MEMADDR     12'h010
`define REG_MEMDATA     12'h014
// ==========================================
// control register fields
`define CTRL_PROG_BIT   0
`define CTRL_COMMIT_BIT 1
`define CTRL_ERASE_BIT  2
// ==========================================
// status register fields
`define STAT_PROG_BIT   0
`define STAT_BUSY_BIT   1
`define STAT_WLOCK_BIT  2
`define STAT_RPROT_BIT  3
`define STAT_REFUSE_BIT 4
// ==========================================
// option byte fields and erased values
`define OPT0_RESERVED_BIT 7
`define OPT0_RANGE_HI   6
`define OPT0_RANGE_LO   4
`define OPT0_SEC_HI     3
`define OPT0_SEC_LO     2
`define OPT0_RPROT_BIT  1
`define OPT0_WLOCK_BIT  0
`define OPT1_MULT_BIT   7
`define OPT1_BYP_BIT    6
`define OPT1_TBYP_BIT   5
`define OPT1_RCOFF_BIT  4
`define OPT1_BOR_HI     3
`define OPT1_BOR_LO     2
`define OPT1_WDSW_BIT   1
`define OPT1_WDHALT_BIT 0
`define OPT0_DEFAULT    8'hfc
`define OPT1_DEFAULT    8'hef
`define MEM_ERASED      8'hff
`define RANGE_RESERVED  3'h6
`define MEM_DEPTH       64
`define MEM_AW          6
`define ERASE_COUNT     7'h40
`endif

/* File: verilog/prog_mem.v */
`timescale 1ns/1ps
`include "option_cfg_regs.vh"
// ==========================================
// small program store, registered read data
module prog_mem (
   // clock
   input  wire                  pclk,
   // write port
   input  wire                  we,
   input  wire [`MEM_AW-1:0]    waddr,
   input  wire [7:0]            wdata,
   // read port
   input  wire [`MEM_AW-1:0]    raddr,
   output reg  [7:0]            rdata
);
   reg [7:0] mem [0:`MEM_DEPTH-1];

   // write then registered read; contents set by the erase sweep while the part is blank
   always @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // prog_mem

/* File: verilog/option_byte_config_decoder.v */
`timescale 1ns/1ps
`include "option_cfg_regs.vh"
// Contract
// - option bytes change only while programming mode is set; other writes ignored
// - with rc off, byte 0 bits 6:4 pick resonator range or external clock
// - byte 0 bits 3:2 set boot sector size 0.5k,1k,2k,4k
// - byte 0 bit 1 blocks program memory read-out and flash writes
// - erasing options under read-out protection erases whole program memory first
// - byte 0 bit 0 one means program memory write protected
// - once write protected, program memory and that bit never change again
// - byte 1 bit 7 selects multiplier times four or times eight
// - byte 1 bit 6 one bypasses the main multiplier
// - byte 1 bit 5 one bypasses the timer multiplier
// - byte 1 bit 4 zero selects internal rc oscillator
// - byte 1 bits 3:2 choose brownout threshold or off
// - byte 1 bit 1 zero forces watchdog permanently on
// - byte 1 bit 0 one resets on stop with watchdog active
// - program memory starts at erased value ff
module option_byte_config_decoder (
   // apb slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // decoded clock settings
   output reg  [2:0]  clock_source_range,
   output reg         external_clock_input,
   output reg         range_reserved,
   output reg         long_start_delay,
   output reg         freq_mult_factor_sel,
   output reg         freq_mult_bypass,
   output reg         timer_mult_bypass,
   output reg         rc_osc_enable,
   // decoded protection and sector settings
   output reg  [1:0]  boot_sector_size,
   output reg         readout_protect,
   output reg         program_write_lock,
   // decoded supervisor and watchdog settings
   output reg  [1:0]  brownout_threshold_sel,
   output reg         brownout_enable,
   output reg         watchdog_software_mode,
   output reg         watchdog_hw_enable,
   output reg         watchdog_reset_on_stop
);
   // ==========================================
   // register map, one byte of data per word
   //   000  option byte 0 stage; reads show the committed cell (prog mode only)
   //   004  option byte 1 stage; reads show the committed cell (prog mode only)
   //   008  control: bit0 prog mode, bit1 commit stage, bit2 erase options
   //   00c  status: bit0 prog, bit1 busy, bit2 write lock, bit3 read-out lock,
   //        bit4 refused (sticky, write one to clear)
   //   010  memory address, 6 bits
   //   014  memory data: hidden under read-out lock, unwritable under either lock
   // commit and erase act only if prog mode was already set before the write,
   // so a single write cannot both enter prog mode and change the options
   // ==========================================
   // state
   localparam ST_SWEEP = 3'b001;
   localparam ST_IDLE  = 3'b010;
   localparam ST_LOAD  = 3'b100;

   reg [2:0]          state;
   // option cells and the blank-memory mark model flash: they take their
   // shipped values at power-up and are deliberately left out of presetn
   reg [7:0]          nv_opt0   = `OPT0_DEFAULT;
   reg [7:0]          nv_opt1   = `OPT1_DEFAULT;
   reg                mem_blank = 1'b1;
   reg [7:0]          stage0;
   reg [7:0]          stage1;
   reg                prog_mode;
   reg                refused;
   reg [6:0]          sweep_cnt;
   reg [`MEM_AW-1:0]  mem_addr;
   reg                mem_we;
   reg [`MEM_AW-1:0]  mem_waddr;
   reg [7:0]          mem_wdata;
   wire [7:0]         mem_rdata;
   reg                pending_erase;

   wire access  = psel & penable & pready;
   wire wr      = access & pwrite;
   wire a_opt0  = (paddr == `REG_OPT0);
   wire a_opt1  = (paddr == `REG_OPT1);
   wire a_ctrl  = (paddr == `REG_CTRL);
   wire a_stat  = (paddr == `REG_STATUS);
   wire a_maddr = (paddr == `REG_MEMADDR);
   wire a_mdata = (paddr == `REG_MEMDATA);
   wire mapped  = a_opt0 | a_opt1 | a_ctrl | a_stat | a_maddr | a_mdata;
   wire busy    = (state != ST_IDLE);
   wire wlocked = nv_opt0[`OPT0_WLOCK_BIT];
   wire rlocked = nv_opt0[`OPT0_RPROT_BIT];

   // option cell updates, decided in idle or in the load state so a reset can never write them
   wire ctrl_go    = wr & a_ctrl & prog_mode & (state == ST_IDLE);
   wire erase_go   = ctrl_go & pwdata[`CTRL_ERASE_BIT];
   wire commit_go  = ctrl_go & ~pwdata[`CTRL_ERASE_BIT] & pwdata[`CTRL_COMMIT_BIT];
   wire opt_clear  = (state == ST_LOAD) | (erase_go & ~wlocked & ~rlocked);
   wire opt_commit = commit_go & ~wlocked;
   wire sweep_last = (state == ST_SWEEP) & (sweep_cnt == `ERASE_COUNT - 7'h01);

   // ==========================================
   // program memory
   prog_mem u_mem (
      .pclk  (pclk),
      .we    (mem_we),
      .waddr (mem_waddr),
      .wdata (mem_wdata),
      .raddr (mem_addr),
      .rdata (mem_rdata)
   );

   // ==========================================
   // apb handshake; one wait state gives the memory time to return data
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
      end
   end

   // read mux and error answer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         if (psel & penable & ~pready) begin
            if (!mapped) begin
               pslverr <= 1'b1;
            end else if (a_opt0 & prog_mode) begin
               prdata <= {24'h000000, nv_opt0};
            end else if (a_opt1 & prog_mode) begin
               prdata <= {24'h000000, nv_opt1};
            end else if (a_ctrl) begin
               prdata <= {31'h00000000, prog_mode};
            end else if (a_stat) begin
               prdata <= {27'h0000000, refused, rlocked, wlocked, busy, prog_mode};
            end else if (a_maddr) begin
               prdata <= {26'h0000000, mem_addr};
            end else if (a_mdata & ~rlocked) begin
               prdata <= {24'h000000, mem_rdata};
            end
         end
      end
   end

   // ==========================================
   // non-volatile store, staging, erase sweep and load sequence
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state         <= ST_SWEEP;
         sweep_cnt     <= 7'h00;
         stage0        <= `OPT0_DEFAULT;
         stage1        <= `OPT1_DEFAULT;
         prog_mode     <= 1'b0;
         refused       <= 1'b0;
         mem_addr      <= {`MEM_AW{1'b0}};
         mem_we        <= 1'b0;
         mem_waddr     <= {`MEM_AW{1'b0}};
         mem_wdata     <= `MEM_ERASED;
         pending_erase <= 1'b0;
      end else begin
         mem_we <= 1'b0;
         case (state)
            // fill program memory with the erased value: once while the part is
            // blank, and again for an option erase under read-out protection; a
            // programmed or write-locked memory is never swept by a plain reset
            ST_SWEEP: begin
               if (mem_blank | pending_erase) begin
                  mem_we    <= 1'b1;
                  mem_waddr <= sweep_cnt[`MEM_AW-1:0];
                  mem_wdata <= `MEM_ERASED;
                  sweep_cnt <= sweep_cnt + 7'h01;
               end else begin
                  state <= ST_IDLE;
               end
               if (sweep_last) begin
                  if (pending_erase) begin
                     state <= ST_LOAD;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            // options erased after the memory sweep completes
            ST_LOAD: begin
               pending_erase <= 1'b0;
               state         <= ST_IDLE;
            end
            ST_IDLE: begin
               if (wr & a_ctrl) begin
                  prog_mode <= pwdata[`CTRL_PROG_BIT];
                  if (pwdata[`CTRL_ERASE_BIT] & prog_mode) begin
                     if (wlocked) begin
                        refused <= 1'b1;
                     end else if (rlocked) begin
                        pending_erase <= 1'b1;
                        sweep_cnt     <= 7'h00;
                        state         <= ST_SWEEP;
                     end
                  end else if (pwdata[`CTRL_COMMIT_BIT] & prog_mode & wlocked) begin
                     refused <= 1'b1;
                  end
               end
               if (wr & a_opt0) begin
                  if (prog_mode) begin
                     stage0 <= pwdata[7:0] | 8'h80;
                  end else begin
                     refused <= 1'b1;
                  end
               end
               if (wr & a_opt1) begin
                  if (prog_mode) begin
                     stage1 <= pwdata[7:0];
                  end else begin
                     refused <= 1'b1;
                  end
               end
               if (wr & a_maddr) begin
                  mem_addr <= pwdata[`MEM_AW-1:0];
               end
               if (wr & a_mdata) begin
                  if (prog_mode & ~wlocked & ~rlocked) begin
                     mem_we    <= 1'b1;
                     mem_waddr <= mem_addr;
                     mem_wdata <= pwdata[7:0];
                  end else begin
                     refused <= 1'b1;
                  end
               end
               if (wr & a_stat & pwdata[`STAT_REFUSE_BIT]) begin
                  refused <= 1'b0;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // option cells: no reset, so committed bytes survive presetn and reach the
   // decoder at the next reset; the commit strobe fires only in idle, the clear in idle or in the load state
   always @(posedge pclk) begin
      if (opt_clear) begin
         nv_opt0 <= `OPT0_DEFAULT;
         nv_opt1 <= `OPT1_DEFAULT;
      end else if (opt_commit) begin
         nv_opt0 <= stage0;
         nv_opt1 <= stage1;
      end
      if (sweep_last) begin
         mem_blank <= 1'b0;
      end
   end

   // ==========================================
   // decoded settings: copied from the option cells at the first edge after
   // reset, then frozen so a commit never disturbs the clocks mid-run
   reg loaded;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded                 <= 1'b0;
         clock_source_range     <= 3'h7;
         external_clock_input   <= 1'b0;
         range_reserved         <= 1'b0;
         long_start_delay       <= 1'b1;
         freq_mult_factor_sel   <= 1'b1;
         freq_mult_bypass       <= 1'b1;
         timer_mult_bypass      <= 1'b1;
         rc_osc_enable          <= 1'b1;
         boot_sector_size       <= 2'h3;
         readout_protect        <= 1'b0;
         program_write_lock     <= 1'b0;
         brownout_threshold_sel <= 2'h3;
         brownout_enable        <= 1'b0;
         watchdog_software_mode <= 1'b1;
         watchdog_hw_enable     <= 1'b0;
         watchdog_reset_on_stop <= 1'b1;
      end else if (!loaded) begin
         loaded                 <= 1'b1;
         clock_source_range     <= nv_opt0[`OPT0_RANGE_HI:`OPT0_RANGE_LO];
         external_clock_input   <= nv_opt1[`OPT1_RCOFF_BIT] & nv_opt0[`OPT0_RANGE_LO]
                                   & nv_opt0[`OPT0_RANGE_HI];
         range_reserved         <= nv_opt1[`OPT1_RCOFF_BIT] &
                                   (nv_opt0[`OPT0_RANGE_HI:`OPT0_RANGE_LO] == `RANGE_RESERVED);
         long_start_delay       <= ~nv_opt1[`OPT1_RCOFF_BIT] &
                                   (&nv_opt0[`OPT0_RANGE_HI:`OPT0_RANGE_LO]);
         freq_mult_factor_sel   <= nv_opt1[`OPT1_MULT_BIT];
         freq_mult_bypass       <= nv_opt1[`OPT1_BYP_BIT];
         timer_mult_bypass      <= nv_opt1[`OPT1_TBYP_BIT];
         rc_osc_enable          <= ~nv_opt1[`OPT1_RCOFF_BIT];
         boot_sector_size       <= nv_opt0[`OPT0_SEC_HI:`OPT0_SEC_LO];
         readout_protect        <= nv_opt0[`OPT0_RPROT_BIT];
         program_write_lock     <= nv_opt0[`OPT0_WLOCK_BIT];
         brownout_threshold_sel <= nv_opt1[`OPT1_BOR_HI:`OPT1_BOR_LO];
         brownout_enable        <= ~(&nv_opt1[`OPT1_BOR_HI:`OPT1_BOR_LO]);
         watchdog_software_mode <= nv_opt1[`OPT1_WDSW_BIT];
         watchdog_hw_enable     <= ~nv_opt1[`OPT1_WDSW_BIT];
         watchdog_reset_on_stop <= nv_opt1[`OPT1_WDHALT_BIT];
      end
   end
endmodule // option_byte_config_decoder

/* File: test/option_byte_config_decoder_asserts.sv */
`timescale 1ns/1ps
// ==========================================
// port checker for the option decoder
module option_cfg_checker (
   // apb side
   input wire        pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire [11:0] paddr,
   input wire [31:0] pwdata, prdata,
   // decoded settings
   input wire [2:0]  clock_source_range,
   input wire [1:0]  boot_sector_size, brownout_threshold_sel,
   input wire        external_clock_input, range_reserved, long_start_delay, freq_mult_factor_sel,
   input wire        freq_mult_bypass, timer_mult_bypass, rc_osc_enable, readout_protect,
   input wire        program_write_lock, brownout_enable, watchdog_software_mode, watchdog_hw_enable,
   input wire        watchdog_reset_on_stop
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // all settings in one vector so a single stray bit shows
   wire [19:0] decoded = {clock_source_range, external_clock_input, range_reserved, long_start_delay,
      freq_mult_factor_sel, freq_mult_bypass, timer_mult_bypass, rc_osc_enable, boot_sector_size,
      readout_protect, program_write_lock, brownout_threshold_sel, brownout_enable,
      watchdog_software_mode, watchdog_hw_enable, watchdog_reset_on_stop};
   // a transfer is a setup step followed by an access step
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable && !pready; endsequence
   property p_answer; s_setup ##1 s_access |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("pready late");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("pready held");
   property p_in_access; pready |-> psel && penable; endproperty
   a_in_access: assert property (p_in_access) else $error("pready outside access");
   property p_unmapped; pready |-> (pslverr == !(paddr[1:0] == 2'h0 && paddr <= 12'h014)); endproperty
   a_unmapped: assert property (p_unmapped) else $error("pslverr wrong");
   property p_idle_data; !pready |-> prdata == 32'h0; endproperty
   a_idle_data: assert property (p_idle_data) else $error("prdata not zero");
   property p_static; $past(presetn, 2) |-> $stable(decoded); endproperty
   a_static: assert property (p_static) else $error("settings moved");
   property p_defaults; $rose(presetn) |-> decoded == 20'he7f35; endproperty
   a_defaults: assert property (p_defaults) else $error("settings not default");
   property p_clock; external_clock_input == (!rc_osc_enable && clock_source_range[2] && clock_source_range[0])
      && range_reserved == (!rc_osc_enable && clock_source_range == 3'h6)
      && long_start_delay == (rc_osc_enable && clock_source_range == 3'h7); endproperty
   a_clock: assert property (p_clock) else $error("clock decode");
   property p_super; brownout_enable == (brownout_threshold_sel != 2'h3)
      && watchdog_hw_enable == !watchdog_software_mode; endproperty
   a_super: assert property (p_super) else $error("supervisor decode");
endmodule // option_cfg_checker
bind option_byte_config_decoder option_cfg_checker chk_u (.*);

/* File: test/prog_tool.sv */
`timescale 1ns/1ps
// ==========================================
// programming tool: apb master facing the option store
module prog_tool #(
   parameter bit low_supply = 1'b1
) (
   // clock
   input  wire         pclk,
   // request
   output logic        psel,
   output logic        penable,
   output logic        pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   // answer
   input  wire  [31:0] prdata,
   input  wire         pready,
   input  wire         pslverr
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata} <= '0;
   end
   // hold the request until pready is seen; idle lines never show old data
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
   endtask
   // stage both bytes as a careful tool would
   task automatic put_options(input logic [7:0] b0, input logic [7:0] b1);
      logic [31:0] q;
      logic        e;
      b0[7] = 1'b1;
      if (!b1[4]) b0[6:4] = 3'h7;
      if (low_supply && !b1[6]) b1[7] = 1'b0;
      xfer(1'b1, 12'h000, {24'h0, b0}, q, e);
      xfer(1'b1, 12'h004, {24'h0, b1}, q, e);
   endtask
endmodule // prog_tool

/* File: test/option_byte_config_decoder_tb.sv */
`timescale 1ns/1ps
`include "option_cfg_regs.vh"
// ==========================================
// bench
module option_byte_config_decoder_tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   wire         psel, penable, pwrite, pready, pslverr;
   wire  [11:0] paddr;
   wire  [31:0] pwdata, prdata;
   wire  [2:0]  clock_source_range;
   wire  [1:0]  boot_sector_size, brownout_threshold_sel;
   wire         external_clock_input, range_reserved, long_start_delay, freq_mult_factor_sel;
   wire         freq_mult_bypass, timer_mult_bypass, rc_osc_enable, readout_protect, program_write_lock;
   wire         brownout_enable, watchdog_software_mode, watchdog_hw_enable, watchdog_reset_on_stop;
   wire  [19:0] decoded = {clock_source_range, external_clock_input, range_reserved, long_start_delay,
      freq_mult_factor_sel, freq_mult_bypass, timer_mult_bypass, rc_osc_enable, boot_sector_size,
      readout_protect, program_write_lock, brownout_threshold_sel, brownout_enable,
      watchdog_software_mode, watchdog_hw_enable, watchdog_reset_on_stop};
   int          n_mismatch = 0;
   int          checked = 0;
   int          cycles = 0;
   logic [31:0] q;
   logic        e;
   option_byte_config_decoder dut_u (.*);
   prog_tool tool_u (.*);
   always #20 pclk = ~pclk;
   task automatic close_out;
      if (n_mismatch == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // a hang ends the run as a failure
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         close_out;
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      tool_u.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      tool_u.xfer(1'b0, a, 32'h0, d, e);
   endtask
   // sweeps take 64 cycles; poll status with a bounded count
   task automatic wait_idle;
      for (int i = 0; i < 40; i++) begin
         rd(`REG_STATUS, q);
         if (q[`STAT_BUSY_BIT] === 1'b0) break;
      end
      check("busy", q[`STAT_BUSY_BIT], 1'b0);
   endtask
   // option cells survive reset, so the decode reflects the last commit
   task automatic do_reset(input logic [19:0] exp_dec);
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      wait_idle;
      check("decoded", decoded, exp_dec);
   endtask
   // normal mode: writes refused, option reads give zero; prog mode: cell read back, unmapped flagged
   task automatic s_gate;
      wr(`REG_OPT1, 32'h5a);
      rd(`REG_OPT1, q);
      check("opt1 normal", q, 32'h0);
      rd(`REG_STATUS, q);
      check("refused", q[`STAT_REFUSE_BIT], 1'b1);
      wr(`REG_STATUS, 32'h10);
      wr(`REG_CTRL, 32'h1);
      rd(`REG_STATUS, q);
      check("status", q[4:0], 5'h01);
      rd(`REG_OPT1, q);
      check("opt1 prog", q, 32'hef);
      rd(12'h018, q);
      check("unmapped", e, 1'b1);
   endtask
   // staged bytes, forced reserved bit, commit leaves settings alone
   task automatic s_commit;
      tool_u.put_options(8'h5c, 8'hd3);
      wr(`REG_OPT0, 32'h5c);
      wr(`REG_CTRL, 32'h3);
      rd(`REG_OPT0, q);
      check("opt0 commit", q, 32'hdc);
      rd(`REG_OPT1, q);
      check("opt1 commit", q, 32'hd3);
      check("decoded", decoded, 20'he7f35);
      wr(`REG_MEMADDR, 32'h5);
      rd(`REG_MEMDATA, q);
      check("mem erased", q, 32'hff);
      wr(`REG_MEMDATA, 32'h3c);
      rd(`REG_MEMDATA, q);
      check("mem data", q, 32'h3c);
      // external clock on, multiplier bypassed, sector 4k, lowest threshold
      do_reset(20'hb330d);
   endtask
   // read-out protection, then option erase wipes memory first
   task automatic s_readout;
      wr(`REG_CTRL, 32'h1);
      wr(`REG_MEMADDR, 32'h5);
      tool_u.put_options(8'h02, 8'h8a);
      wr(`REG_CTRL, 32'h3);
      rd(`REG_MEMDATA, q);
      check("mem hidden", q, 32'h0);
      wr(`REG_MEMDATA, 32'h11);
      rd(`REG_STATUS, q);
      check("status rprot", q[4:3], 2'h3);
      wr(`REG_CTRL, 32'h5);
      wait_idle;
      wr(`REG_STATUS, 32'h10);
      rd(`REG_MEMDATA, q);
      check("mem wiped", q, 32'hff);
      rd(`REG_OPT1, q);
      check("opt1 erased", q, 32'hef);
   endtask
   // write lock refuses memory, commit and erase for good
   task automatic s_wlock;
      wr(`REG_CTRL, 32'h1);
      tool_u.put_options(8'h01, 8'h8a);
      wr(`REG_CTRL, 32'h3);
      wr(`REG_MEMDATA, 32'h22);
      rd(`REG_MEMDATA, q);
      check("mem locked", q, 32'hff);
      wr(`REG_OPT1, 32'hef);
      wr(`REG_CTRL, 32'h3);
      wr(`REG_CTRL, 32'h5);
      wait_idle;
      rd(`REG_OPT1, q);
      check("opt1 locked", q, 32'h0a);
      rd(`REG_STATUS, q);
      check("status wlock", q[4:2], 3'h5);
   endtask
   initial begin
      do_reset(20'he7f35);
      s_gate;
      s_commit;
      s_readout;
      s_wlock;
      do_reset(20'he446c);
      close_out;
   end
endmodule // option_byte_config_decoder_tb
